// [core/psp_serial_ports.sv]
`timescale 1ns/10ps
`default_nettype none
`include "psp_regs.svh"

module psp_serial_ports import psp_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic p0_bit_clk_i,
	output logic p0_bit_clk_o,
	output logic p0_bit_clk_oe_o,
	input wire logic p0_frame_sync_i,
	output logic p0_frame_sync_o,
	output logic p0_frame_sync_oe_o,
	input wire logic p0_pcm_serial_in_i,
	output logic p0_pcm_serial_out_o,
	input wire logic p1_bit_clk_i,
	output logic p1_bit_clk_o,
	output logic p1_bit_clk_oe_o,
	input wire logic p1_frame_sync_i,
	output logic p1_frame_sync_o,
	output logic p1_frame_sync_oe_o,
	input wire logic p1_pcm_serial_in_i,
	output logic p1_pcm_serial_out_o,
	output logic audio_master_clk_o,
	output logic audio_master_clk_oe_o
);

	////////////////////////////////////////////////////////////////////////////
	// Register bus slave

	logic ack_ff; // Acknowledge, one cycle per request
	logic [31:0] rdat_ff; // Registered read data
	logic [`PSP_CTRL_W-1:0] ctrl_ff; // Control register
	logic [31:0] nxt_rdat; // Read mux result
	logic bus_req; // Live request
	logic wr_now; // Write takes effect at this edge
	logic rd_now; // Read completes at this edge
	logic hit_status; // Status register addressed
	wire logic [31:0] tx_word [2]; // Transmit words per port
	wire logic [31:0] rx_word [2]; // Received words per port
	wire logic [1:0] rx_valid; // New word flags per port
	wire logic [1:0] rx_ovr; // Overrun flags per port

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	assign bus_req = wb_cyc_i & wb_stb_i;
	assign wr_now = bus_req & ack_ff & wb_we_i;
	assign rd_now = bus_req & ack_ff & ~wb_we_i;
	assign hit_status = (wb_adr_i == `PSP_OFF_STATUS);
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		case (wb_adr_i)
			`PSP_OFF_CTRL: nxt_rdat = {27'h0000000, ctrl_ff};
			`PSP_OFF_STATUS: nxt_rdat = {28'h0000000, rx_ovr, rx_valid};
			`PSP_OFF_TX0: nxt_rdat = tx_word[0];
			`PSP_OFF_RX0: nxt_rdat = rx_word[0];
			`PSP_OFF_TX1: nxt_rdat = tx_word[1];
			`PSP_OFF_RX1: nxt_rdat = rx_word[1];
			default: nxt_rdat = 32'h00000000;
		endcase
	end

	// Read data captured as the ack rises
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdat_ff <= 32'h00000000;
		end else if (bus_req & ~ack_ff) begin
			rdat_ff <= nxt_rdat;
		end
	end

	// Control register: port select, master and framing bits
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= `PSP_CTRL_RST;
		end else if (wr_now && wb_adr_i == `PSP_OFF_CTRL && wb_sel_i[0]) begin
			ctrl_ff <= wb_dat_i[`PSP_CTRL_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain: reset release, settings and clock divider

	logic lrst_s1_ff; // Link reset release, first stage
	logic lrst_n_ff; // Link reset, released on the link clock
	logic [`PSP_CTRL_W-1:0] cfg_s1_ff; // Settings crossing, first stage
	logic [`PSP_CTRL_W-1:0] cfg_ff; // Settings in link domain
	logic [3:0] div_ff; // Link clock divider
	logic [1:0] eng_master; // Port drives its own clocks
	psp_fmt_t eng_fmt [2]; // Framing per port
	wire logic [1:0] bck_pin; // Bit clock pins in
	wire logic [1:0] fs_pin; // Frame sync pins in
	wire logic [1:0] din_pin; // Serial data pins in
	wire logic [1:0] dout_pin; // Serial data out
	wire logic [1:0] fs_out; // Frame sync out

	// Reset asserts at once, releases in step with the link clock
	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lrst_s1_ff <= 1'b0;
			lrst_n_ff <= 1'b0;
		end else begin
			lrst_s1_ff <= 1'b1;
			lrst_n_ff <= lrst_s1_ff;
		end
	end

	// Quasi-static settings pass two flip-flops
	always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			cfg_s1_ff <= `PSP_CTRL_RST;
			cfg_ff <= `PSP_CTRL_RST;
		end else begin
			cfg_s1_ff <= ctrl_ff;
			cfg_ff <= cfg_s1_ff;
		end
	end

	// Free-running divider: mclk 256 fs, bit clock 32 fs
	always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	assign eng_master[0] = cfg_ff[`PSP_CTRL_P0_MASTER];
	assign eng_master[1] = cfg_ff[`PSP_CTRL_P1_MASTER];
	assign eng_fmt[0] = cfg_ff[`PSP_CTRL_P0_SSI] ? PSP_FMT_SSI : PSP_FMT_TDM;
	assign eng_fmt[1] = cfg_ff[`PSP_CTRL_I2S_SEL] ? PSP_FMT_I2S :
		(cfg_ff[`PSP_CTRL_P1_SSI] ? PSP_FMT_SSI : PSP_FMT_TDM);

	////////////////////////////////////////////////////////////////////////////
	// Pins

	assign bck_pin = {p1_bit_clk_i, p0_bit_clk_i};
	assign fs_pin = {p1_frame_sync_i, p0_frame_sync_i}; // Port one: audio_word_select_clock
	assign din_pin = {p1_pcm_serial_in_i, p0_pcm_serial_in_i};
	assign p0_pcm_serial_out_o = dout_pin[0];
	assign p1_pcm_serial_out_o = dout_pin[1];
	assign p0_frame_sync_o = fs_out[0];
	assign p1_frame_sync_o = fs_out[1];
	assign p0_frame_sync_oe_o = eng_master[0];
	assign p1_frame_sync_oe_o = eng_master[1];
	assign p0_bit_clk_o = div_ff[`PSP_BCLK_BIT];
	assign p1_bit_clk_o = div_ff[`PSP_BCLK_BIT];
	assign p0_bit_clk_oe_o = eng_master[0];
	assign p1_bit_clk_oe_o = eng_master[1];
	assign audio_master_clk_o = div_ff[0];
	assign audio_master_clk_oe_o = eng_master[1] & cfg_ff[`PSP_CTRL_I2S_SEL];

	////////////////////////////////////////////////////////////////////////////
	// Serial engines, one per port

	for (genvar g = 0; g < 2; g++) begin : g_eng
		localparam logic [7:0] OFF_TX = (g == 0) ? `PSP_OFF_TX0 : `PSP_OFF_TX1;
		localparam logic [7:0] OFF_RX = (g == 0) ? `PSP_OFF_RX0 : `PSP_OFF_RX1;
		logic [31:0] tx_ff; // Transmit word, bus side
		logic tx_tgl_ff; // Flips on each transmit write
		logic [31:0] rx_ff; // Received word, bus side
		logic valid_ff; // New word not yet read
		logic ovr_ff; // Word lost before read
		logic [2:0] rs_ff; // Frame toggle crossing
		logic new_frame; // Frame arrived on bus side
		logic [2:0] ts_ff; // Transmit toggle crossing
		logic [31:0] txsh_ff; // Transmit word, link side
		logic [31:0] txcur_ff; // Word being shifted out
		logic [2:0] bck_s_ff; // Bit clock sync and edge stage
		logic [1:0] fs_s_ff; // Frame sync sync
		logic [1:0] din_s_ff; // Data in sync
		logic fs_last_ff; // Frame sync at previous rise
		logic [4:0] pos_ff; // Bit position at last rise
		logic [15:0] sh_ff; // Receive shifter
		logic [31:0] rxw_ff; // Received word, link side
		logic rx_tgl_ff; // Flips on each whole frame
		logic dout_ff; // Serial data out
		logic fsout_ff; // Frame sync out in master mode
		logic rise; // Sampling edge of the bit clock
		logic fall; // Driving edge of the bit clock
		logic start; // Slave frame start seen
		logic [4:0] cur_pos; // Position of bit sampled now
		logic [4:0] nxt_pos; // Position of next bit driven
		logic [15:0] word; // Word completed by this bit
		logic tx_bit; // Bit for next position

		// Bus side: transmit word written by software
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				tx_ff <= 32'h00000000;
				tx_tgl_ff <= 1'b0;
			end else if (wr_now && wb_adr_i == OFF_TX) begin
				tx_ff <= lane_merge(tx_ff, wb_dat_i, wb_sel_i);
				tx_tgl_ff <= ~tx_tgl_ff;
			end
		end

		// Frame toggle from link domain, then edge
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				rs_ff <= 3'h0;
			end else begin
				rs_ff <= {rs_ff[1:0], rx_tgl_ff};
			end
		end
		assign new_frame = rs_ff[1] ^ rs_ff[2];

		// Received word copied while link side holds it still
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				rx_ff <= 32'h00000000;
			end else if (new_frame) begin
				rx_ff <= rxw_ff;
			end
		end

		// Valid flag: a new frame wins over the read clear
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				valid_ff <= 1'b0;
			end else if (new_frame) begin
				valid_ff <= 1'b1;
			end else if (rd_now && wb_adr_i == OFF_RX) begin
				valid_ff <= 1'b0;
			end
		end

		// Overrun flag: cleared by a status read, set wins
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				ovr_ff <= 1'b0;
			end else if (new_frame && valid_ff) begin
				ovr_ff <= 1'b1;
			end else if (rd_now && hit_status) begin
				ovr_ff <= 1'b0;
			end
		end

		assign tx_word[g] = tx_ff;
		assign rx_word[g] = rx_ff;
		assign rx_valid[g] = valid_ff;
		assign rx_ovr[g] = ovr_ff;

		// Link side: pin synchronisers and transmit toggle crossing
		always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
			if (!lrst_n_ff) begin
				bck_s_ff <= 3'h0;
				fs_s_ff <= 2'h0;
				din_s_ff <= 2'h0;
				ts_ff <= 3'h0;
			end else begin
				bck_s_ff <= {bck_s_ff[1:0], bck_pin[g]};
				fs_s_ff <= {fs_s_ff[0], fs_pin[g]};
				din_s_ff <= {din_s_ff[0], din_pin[g]};
				ts_ff <= {ts_ff[1:0], tx_tgl_ff};
			end
		end

		// Edges: own divider in master, partner's clock in slave
		assign rise = eng_master[g] ? (div_ff == `PSP_DIV_RISE) : (bck_s_ff[1] & ~bck_s_ff[2]);
		assign fall = eng_master[g] ? (div_ff == `PSP_DIV_FALL) : (~bck_s_ff[1] & bck_s_ff[2]);

		// Frame start by format: word select fall, sync pulse or strobe
		always_comb begin
			case (eng_fmt[g])
				PSP_FMT_I2S: start = fs_last_ff & ~fs_s_ff[1];
				PSP_FMT_TDM: start = fs_last_ff;
				PSP_FMT_SSI: start = fs_s_ff[1] & ~fs_last_ff;
				default: start = 1'b0;
			endcase
		end
		assign cur_pos = (!eng_master[g] && start) ? 5'h00 : pos_ff + 5'h01;
		assign nxt_pos = pos_ff + 5'h01;
		assign word = {sh_ff[14:0], din_s_ff[1]};

		// Bit for the next position, MSB first
		always_comb begin
			case (eng_fmt[g])
				PSP_FMT_I2S: begin
					if (nxt_pos != 5'h00 && nxt_pos <= `PSP_POS_I2S_LEFT) begin
						tx_bit = txcur_ff[4'(5'h10 - nxt_pos)];
					end else begin
						tx_bit = txcur_ff[5'h10 + 5'(4'(5'h00 - nxt_pos))];
					end
				end
				PSP_FMT_TDM, PSP_FMT_SSI: begin
					tx_bit = nxt_pos[4] ? 1'b0 : txcur_ff[~nxt_pos[3:0]];
				end
				default: tx_bit = 1'b0;
			endcase
		end

		// Position, receive shifter and received words at the rise
		always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
			if (!lrst_n_ff) begin
				pos_ff <= 5'h00;
				fs_last_ff <= 1'b0;
				sh_ff <= 16'h0000;
				rxw_ff <= 32'h00000000;
				rx_tgl_ff <= 1'b0;
			end else if (rise) begin
				pos_ff <= cur_pos;
				fs_last_ff <= fs_s_ff[1];
				sh_ff <= word;
				if (eng_fmt[g] == PSP_FMT_I2S) begin
					if (cur_pos == `PSP_POS_I2S_LEFT) begin
						rxw_ff[15:0] <= word;
					end else if (cur_pos == 5'h00) begin
						rxw_ff[31:16] <= word;
						rx_tgl_ff <= ~rx_tgl_ff;
					end
				end else if (cur_pos == `PSP_POS_PCM_LAST) begin
					rxw_ff <= {16'h0000, word};
					rx_tgl_ff <= ~rx_tgl_ff;
				end
			end
		end

		// Transmit word taken over only on a toggle change
		always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
			if (!lrst_n_ff) begin
				txsh_ff <= 32'h00000000;
			end else if (ts_ff[1] ^ ts_ff[2]) begin
				txsh_ff <= tx_ff;
			end
		end

		// Data and master frame sync change at the fall
		always_ff @(posedge link_clk_i or negedge lrst_n_ff) begin
			if (!lrst_n_ff) begin
				txcur_ff <= 32'h00000000;
				dout_ff <= 1'b0;
				fsout_ff <= 1'b0;
			end else if (fall) begin
				if (nxt_pos == ((eng_fmt[g] == PSP_FMT_I2S) ? 5'h01 : 5'h00)) begin
					txcur_ff <= txsh_ff;
				end
				dout_ff <= tx_bit;
				case (eng_fmt[g])
					PSP_FMT_I2S: fsout_ff <= nxt_pos[4];
					PSP_FMT_TDM: fsout_ff <= (nxt_pos == `PSP_POS_TDM_SYNC);
					PSP_FMT_SSI: fsout_ff <= ~nxt_pos[4];
					default: fsout_ff <= 1'b0;
				endcase
			end
		end

		assign dout_pin[g] = dout_ff;
		assign fs_out[g] = fsout_ff;
	end

endmodule : psp_serial_ports
`default_nettype wire

// [core/psp_regs.svh]
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// Register byte offsets on the bus
`define PSP_OFF_CTRL 8'h00
`define PSP_OFF_STATUS 8'h04
`define PSP_OFF_TX0 8'h08
`define PSP_OFF_RX0 8'h0c
`define PSP_OFF_TX1 8'h10
`define PSP_OFF_RX1 8'h14

// Control register fields
`define PSP_CTRL_I2S_SEL 0
`define PSP_CTRL_P0_MASTER 1
`define PSP_CTRL_P1_MASTER 2
`define PSP_CTRL_P0_SSI 3
`define PSP_CTRL_P1_SSI 4
`define PSP_CTRL_W 5
`define PSP_CTRL_RST 5'h00

// Status register fields
`define PSP_STAT_VALID 0
`define PSP_STAT_OVR 2

// Link clock divider: master clock = link/2, bit clock = link/16
`define PSP_DIV_RISE 4'h7
`define PSP_DIV_FALL 4'hf
`define PSP_BCLK_BIT 3

// Frame shape: 32 bit clocks per frame, 16-bit words
`define PSP_WORD_W 16
`define PSP_POS_I2S_LEFT 5'h10
`define PSP_POS_PCM_LAST 5'h0f
`define PSP_POS_TDM_SYNC 5'h1f

`endif

// [core/psp_pkg.sv]
package psp_pkg;

	// Serial framing of one port
	typedef enum logic [1:0] {
		PSP_FMT_TDM,
		PSP_FMT_SSI,
		PSP_FMT_I2S
	} psp_fmt_t;

endpackage : psp_pkg

// [verif/psp_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module psp_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic p0_bit_clk_o,
	input wire logic p0_bit_clk_oe_o,
	input wire logic p0_pcm_serial_out_o,
	input wire logic p1_bit_clk_o,
	input wire logic p1_bit_clk_oe_o,
	input wire logic p1_frame_sync_o,
	input wire logic p1_frame_sync_oe_o,
	input wire logic p1_pcm_serial_out_o,
	input wire logic audio_master_clk_o,
	input wire logic audio_master_clk_oe_o
);
	////////////////////////////////////////
	// Bit clock phases of eight link cycles each
	sequence s_hi8;
		p1_bit_clk_o [*8] ##1 !p1_bit_clk_o;
	endsequence
	sequence s_lo8;
		!p1_bit_clk_o [*8] ##1 p1_bit_clk_o;
	endsequence
	////////////////////////////////////////
	// Bus answers one cycle after a fresh request
	a_ack_after_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not one cycle after request");
	a_ack_one_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	// Master clock drives only with port one as clock master
	a_mclk_needs_master: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		audio_master_clk_oe_o |-> p1_bit_clk_oe_o && p1_frame_sync_oe_o) else $error("mclk driven in slave");
	// Bit clock high and low phases
	a_bclk_high_len: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$rose(p1_bit_clk_o) |-> s_hi8) else $error("bit clock high phase wrong");
	a_bclk_low_len: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$fell(p1_bit_clk_o) |-> s_lo8) else $error("bit clock low phase wrong");
	// Master clock toggles every link cycle while driven
	a_mclk_toggles: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$past(audio_master_clk_oe_o) |-> audio_master_clk_o != $past(audio_master_clk_o))
		else $error("master clock not at half link rate");
	// Word select and data move only on bit clock falls
	a_ws_on_fall: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$changed(p1_frame_sync_o) && audio_master_clk_oe_o && $past(audio_master_clk_oe_o) |-> $fell(p1_bit_clk_o))
		else $error("word select off the falling edge");
	a_sd1_on_fall: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$changed(p1_pcm_serial_out_o) && p1_bit_clk_oe_o && $past(p1_bit_clk_oe_o) |-> $fell(p1_bit_clk_o))
		else $error("port one data off the falling edge");
	a_sd0_on_fall: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$changed(p0_pcm_serial_out_o) && p0_bit_clk_oe_o && $past(p0_bit_clk_oe_o) |-> $fell(p0_bit_clk_o))
		else $error("port zero data off the falling edge");
endmodule : psp_monitor
bind psp_serial_ports psp_monitor u_mon (.*);
`default_nettype wire

// [verif/psp_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module psp_partner #(parameter int HALF_NS = 200) (
	input wire logic en_i,
	input wire logic [31:0] tx_i,
	input wire logic sd_i,
	output logic bclk_o,
	output logic ws_o,
	output logic sd_o,
	output logic [31:0] rx_o,
	output logic [7:0] nfrm_o
);
	// Slave-mode audio source; frames follow without pause, clock stands still while disabled
	initial begin
		{bclk_o, ws_o, sd_o, rx_o, nfrm_o} = '0;
		forever begin
			if (!en_i) begin
				#(HALF_NS);
				sd_o = ~sd_o;
			end else begin
				// 32 bit clocks per word select period
				for (int b = 0; b < 32; b++) begin
					ws_o = b >= 15 && b < 31;
					sd_o = b < 16 ? tx_i[15 - b] : tx_i[47 - b];
					#(HALF_NS) bclk_o = 1'h1;
					if (b < 16) rx_o[15 - b] = sd_i;
					else rx_o[47 - b] = sd_i;
					#(HALF_NS) bclk_o = 1'h0;
				end
				nfrm_o++;
			end
		end
	end
endmodule : psp_partner
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", n, e, s); end end
module tb;
	logic clk_i = 1'h0, link_clk_i = 1'h0, rst_n_i = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, p0_bit_clk_o, p0_bit_clk_oe_o, p0_frame_sync_o, p0_frame_sync_oe_o, p0_pcm_serial_out_o;
	logic p1_bit_clk_o, p1_bit_clk_oe_o, p1_frame_sync_o, p1_frame_sync_oe_o, p1_pcm_serial_out_o;
	logic audio_master_clk_o, audio_master_clk_oe_o;
	logic pe = 1'h0, pbclk, pws, psd;
	logic [31:0] ptx = 32'h0, prx;
	logic [7:0] pnf;
	// Port zero loops back as master, follows port one as slave; port one to partner or itself
	wire logic p0_bit_clk_i = p1_bit_clk_o;
	wire logic p0_frame_sync_i = p1_frame_sync_o;
	wire logic p0_pcm_serial_in_i = p0_bit_clk_oe_o ? p0_pcm_serial_out_o : p1_pcm_serial_out_o;
	wire logic p1_bit_clk_i = pbclk;
	wire logic p1_frame_sync_i = pws;
	wire logic p1_pcm_serial_in_i = pe ? psd : p1_pcm_serial_out_o;
	wire logic [2:0] msig = {p1_bit_clk_o, p1_frame_sync_o, audio_master_clk_o};
	logic [2:0] mlast = 3'h0;
	int per[3], mcnt[3], n_errors = 0, n_compared = 0, cycles = 0, seed = 32'h1959;
	psp_serial_ports uut (.*);
	psp_partner u_par (.en_i(pe), .tx_i(ptx), .sd_i(p1_pcm_serial_out_o), .bclk_o(pbclk), .ws_o(pws),
		.sd_o(psd), .rx_o(prx), .nfrm_o(pnf));
	////////////////////////////////////////
	// Clocks, unrelated in phase
	initial forever #25 clk_i = ~clk_i;
	initial begin
		#7;
		forever #24 link_clk_i = ~link_clk_i;
	end
	// Period of mclk, word select and bit clock in link cycles
	always @(posedge link_clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (msig[i] && !mlast[i]) begin
				per[i] <= mcnt[i];
				mcnt[i] <= 1;
			end else begin
				mcnt[i] <= mcnt[i] + 1;
			end
		end
		mlast <= msig;
	end
	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			test_done();
		end
	end
	////////////////////////////////////////
	// One classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int t;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'h1 && t < 40);
		if (t == 40) begin
			n_errors++;
			test_done();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb
	// Frames last 512 link cycles, about 492 bus cycles
	task automatic frames(input int n);
		repeat (n * 500) @(posedge clk_i);
	endtask : frames
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////
	initial begin
		logic [31:0] q, t0, t1;
		int w;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'h1;
		// Reset values and an unmapped place
		wb(1'h0, 8'h00, 32'h0, q); `CHK("ctrl", 32'h0, q)
		wb(1'h1, 8'h3c, 32'hffffffff, q);
		wb(1'h0, 8'h3c, 32'h0, q); `CHK("unmapped", 32'h0, q)
		`CHK("mclk oe", 1'h0, audio_master_clk_oe_o)
		$display("test registers done");
		// PCM masters, then port zero as slave to port one; TDM and sync serial each
		for (int m = 0; m < 4; m++) begin
			t0 = $random(seed);
			t1 = $random(seed);
			wb(1'h1, 8'h00, (m[1] ? 32'h4 : 32'h6) | (m[0] ? 32'h18 : 32'h0), q);
			wb(1'h1, 8'h08, t0, q);
			wb(1'h1, 8'h10, t1, q);
			frames(4);
			`CHK("p0 oe", !m[1], p0_bit_clk_oe_o & p0_frame_sync_oe_o)
			`CHK("pcm mclk oe", 1'h0, audio_master_clk_oe_o)
			wb(1'h0, 8'h0c, 32'h0, q); `CHK("rx0", m[1] ? t1[15:0] : t0[15:0], q[15:0])
			wb(1'h0, 8'h14, 32'h0, q); `CHK("rx1", t1[15:0], q[15:0])
			$display("test pcm mode %0d done", m);
		end
		// Audio port as clock master, looped back
		t1 = $random(seed);
		wb(1'h1, 8'h00, 32'h5, q);
		wb(1'h1, 8'h10, t1, q);
		frames(4);
		`CHK("mclk oe", 1'h1, audio_master_clk_oe_o)
		`CHK("mclk period", 2, per[0])
		`CHK("ws period", 512, per[1])
		`CHK("bclk period", 16, per[2])
		wb(1'h0, 8'h04, 32'h0, q); `CHK("status p1", 2'h3, {q[3], q[1]})
		wb(1'h0, 8'h14, 32'h0, q); `CHK("loop word", t1, q)
		wb(1'h0, 8'h04, 32'h0, q); `CHK("ovr clear", 1'h0, q[3])
		$display("test audio master done");
		// Audio port as clock slave to the partner
		ptx = $random(seed);
		t1 = $random(seed);
		wb(1'h1, 8'h00, 32'h1, q);
		wb(1'h1, 8'h10, t1, q);
		pe <= 1'h1;
		w = 0;
		while (pnf < 5 && w < 20000) begin
			@(posedge clk_i);
			w++;
		end
		if (w == 20000) begin
			n_errors++;
			test_done();
		end
		`CHK("slave mclk oe", 1'h0, audio_master_clk_oe_o)
		`CHK("slave clk oe", 1'h0, p1_bit_clk_oe_o | p1_frame_sync_oe_o)
		wb(1'h0, 8'h14, 32'h0, q); `CHK("slave rx", ptx, q)
		`CHK("slave tx", t1, prx)
		pe <= 1'h0;
		$display("test audio slave done");
		test_done();
	end
endmodule : tb
`default_nettype wire
